// file: core/ldg_pkg.sv
package ldg_pkg;
   // Serial target address, direction bit 0 means write
   localparam logic [6:0] DEV_ADDR = 7'h36;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Register selects
   localparam logic [7:0] REG_GP = 8'h10;
   localparam logic [7:0] REG_BRT_A = 8'ha0;
   localparam logic [7:0] REG_BRT_B = 8'hb0;
   localparam logic [7:0] REG_BRT_C = 8'hc0;
   localparam logic [7:0] REG_RAMP = 8'h20;
   localparam logic [7:0] REG_VF_DLY = 8'h60;
   // Power-on values
   localparam logic [7:0] RST_GP = 8'h00;
   localparam logic [7:0] RST_BRT_A = 8'he0;
   localparam logic [7:0] RST_BRT_B = 8'hf8;
   localparam logic [7:0] RST_BRT_C = 8'hf8;
   localparam logic [7:0] RST_RAMP = 8'hf0;
   localparam logic [7:0] RST_VF_DLY = 8'hfc;
   // General purpose register bits
   localparam int GP_PRI_EN = 0;
   localparam int GP_SEC_EN = 1;
   localparam int GP_IND_EN = 2;
   localparam int GP_SD53 = 3;
   localparam int GP_SD62 = 4;
   localparam int GP_A53 = 5;
   localparam int GP_A62 = 6;
   // Field widths
   localparam int BRT_A_W = 5;
   localparam int BRT_BC_W = 3;
   localparam int RAMP_W = 2;
   localparam int VF_W = 2;
   localparam int SINKS = 8;
   // Clock rate in kHz, 100 ns period
   localparam int CLK_KHZ = 10000;
endpackage

// file: core/ldg_wr_if.sv
`timescale 1ns/1ps
interface ldg_wr_if;
   logic valid;
   logic [7:0] addr;
   logic [7:0] data;
   modport src (output valid, output addr, output data);
   modport dst (input valid, input addr, input data);
endinterface

// file: core/ldg_serial_slave.sv
`timescale 1ns/1ps
module ldg_serial_slave
   import ldg_pkg::*;
(
   input wire logic i_clock, // System clock
   input wire logic i_rst, // Async reset
   input wire logic i_clear, // Sync clear, enable pin low
   input wire logic i_scl, // Serial clock
   input wire logic i_sda, // Serial data in
   output logic o_sda_oe, // Pull data low
   ldg_wr_if.src wr // Accepted write
);
   typedef enum {ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_SKIP} ldg_sst_t;
   ldg_sst_t st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh;
   logic [7:0] reg_ff, nxt_reg;
   logic ack_ff, nxt_ack;
   logic wv_ff, nxt_wv;
   logic [7:0] wd_ff, nxt_wd;
   logic scl_q, sda_q;
   logic rise, fall, start, stop;

   assign rise = i_scl & ~scl_q;
   assign fall = ~i_scl & scl_q;
   assign start = i_scl & scl_q & sda_q & ~i_sda;
   assign stop = i_scl & scl_q & ~sda_q & i_sda;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_reg = reg_ff;
      nxt_ack = ack_ff;
      nxt_wv = 1'b0;
      nxt_wd = wd_ff;
      if (i_clear || stop) begin
         nxt_st = ST_IDLE;
         nxt_ack = 1'b0;
      end else if (start) begin
         nxt_st = ST_ADDR;
         nxt_cnt = 4'h0;
         nxt_ack = 1'b0;
      end else if (st_ff != ST_IDLE && st_ff != ST_SKIP) begin
         if (rise && cnt_ff < BYTE_BITS) begin
            nxt_sh = {sh_ff[6:0], i_sda};
            nxt_cnt = cnt_ff + 4'h1;
         end else if (fall && cnt_ff == BYTE_BITS && !ack_ff) begin
            nxt_ack = 1'b1; // RULE_15
            unique case (st_ff)
               ST_ADDR: begin
                  if (sh_ff[7:1] != DEV_ADDR || sh_ff[0]) begin // RULE_14
                     nxt_ack = 1'b0;
                     nxt_st = ST_SKIP;
                  end
               end
               ST_REG: nxt_reg = sh_ff; // RULE_14
               ST_DATA: begin
                  nxt_wv = 1'b1; // RULE_03
                  nxt_wd = sh_ff;
               end
               default: nxt_st = ST_SKIP;
            endcase
         end else if (fall && ack_ff) begin
            nxt_ack = 1'b0; // RULE_15
            nxt_cnt = 4'h0;
            if (st_ff == ST_ADDR) begin
               nxt_st = ST_REG;
            end else if (st_ff == ST_REG) begin
               nxt_st = ST_DATA;
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         reg_ff <= 8'h00;
         ack_ff <= 1'b0;
         wv_ff <= 1'b0;
         wd_ff <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         reg_ff <= nxt_reg;
         ack_ff <= nxt_ack;
         wv_ff <= nxt_wv;
         wd_ff <= nxt_wd;
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   assign o_sda_oe = ack_ff;
   assign wr.valid = wv_ff;
   assign wr.addr = reg_ff;
   assign wr.data = wd_ff;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_ack_ninth;
      $rose(ack_ff) |-> $past(cnt_ff) == BYTE_BITS && $past(fall);
   endproperty
   a_ack_ninth: assert property (p_ack_ninth) // RULE_15
      else $error("Acknowledge not started after eighth bit");

   property p_write_after_data;
      wv_ff |-> $past(st_ff) == ST_DATA && ack_ff;
   endproperty
   a_write_after_data: assert property (p_write_after_data) // RULE_14
      else $error("Write issued outside data byte");
endmodule

// file: core/ldg_gain_ctl.sv
`timescale 1ns/1ps
module ldg_gain_ctl
   import ldg_pkg::*;
#(
   parameter int CW = 24
) (
   input wire logic i_clock, // System clock
   input wire logic i_rst, // Async reset
   input wire logic i_clear, // Sync clear
   input wire logic i_write, // Any accepted write
   input wire logic [SINKS-1:0] i_hr_low, // Headroom at threshold
   input wire logic [SINKS-1:0] i_mask, // Sink is active
   input wire logic [CW-1:0] i_delay, // Transition delay, cycles
   output logic o_gain_3x2 // Pump in 3/2 gain
);
   typedef enum {GS_PASS, GS_BOOST, GS_REEVAL} ldg_gst_t;
   ldg_gst_t st_ff, nxt_st;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic gain_ff, nxt_gain;
   logic low_any;
   logic done;

   // Lowest headroom of the active sinks decides
   assign low_any = |(i_hr_low & i_mask); // RULE_07 RULE_08
   assign done = cnt_ff >= i_delay - CW'(1);

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_gain = gain_ff;
      if (i_clear) begin
         nxt_st = GS_PASS;
         nxt_cnt = '0;
         nxt_gain = 1'b0;
      end else begin
         unique case (st_ff)
            GS_PASS: begin
               nxt_gain = 1'b0; // RULE_04
               if (!low_any) begin
                  nxt_cnt = '0; // RULE_09
               end else if (done) begin
                  nxt_st = GS_BOOST; // RULE_05
                  nxt_gain = 1'b1;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + CW'(1);
               end
            end
            GS_BOOST: begin
               if (i_write) begin
                  nxt_st = GS_REEVAL; // RULE_06
                  nxt_cnt = '0;
               end
            end
            GS_REEVAL: begin
               if (i_write) begin
                  nxt_cnt = '0; // RULE_16
               end else if (done) begin
                  nxt_cnt = '0;
                  nxt_st = low_any ? GS_BOOST : GS_PASS; // RULE_06
                  nxt_gain = low_any;
               end else begin
                  nxt_cnt = cnt_ff + CW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= GS_PASS;
         cnt_ff <= '0;
         gain_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         gain_ff <= nxt_gain;
      end
   end

   assign o_gain_3x2 = gain_ff;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_boost_after_delay;
      $rose(gain_ff) |->
         $past(cnt_ff) == i_delay - CW'(1) && $past(low_any);
   endproperty
   a_boost_after_delay: assert property (p_boost_after_delay) // RULE_09
      else $error("Gain rose before the transition delay");

   property p_hold_boost;
      gain_ff && !i_write && !i_clear && st_ff == GS_BOOST |=> gain_ff;
   endproperty
   a_hold_boost: assert property (p_hold_boost) // RULE_06
      else $error("Gain left 3/2 without a write");

   sequence s_write_in_boost;
      st_ff == GS_BOOST && i_write && !i_clear;
   endsequence
   property p_reeval_waits;
      s_write_in_boost |=> st_ff == GS_REEVAL && gain_ff;
   endproperty
   a_reeval_waits: assert property (p_reeval_waits) // RULE_16
      else $error("Write did not start a delayed re-evaluation");

   property p_masked_pass;
      st_ff == GS_PASS && !low_any |=> !gain_ff;
   endproperty
   a_masked_pass: assert property (p_masked_pass) // RULE_07
      else $error("Gain rose with no active sink low");
endmodule

// file: core/ldg_top.sv
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Primary group takes a 5-bit code: 32 exponential steps.
// [RULE_02] Secondary and indicator groups take 3-bit codes: 8 linear steps.
// [RULE_03] Enables and brightness change only through serial writes.
// [RULE_04] Ample input keeps the pump in pass mode.
// [RULE_05] Any active sink at about 150mV moves the pump to 3/2.
// [RULE_06] 3/2 holds until a serial write, then gain is chosen again.
// [RULE_07] Only sinks of enabled groups take part in the decision.
// [RULE_08] The sink with the least headroom steers the gain.
// [RULE_09] Dips shorter than the default 3 ms delay do not change gain.
// [RULE_10] Four delay ranges, picked by the monitor delay field.
// [RULE_11] Enable pin low restores all defaults and turns outputs off.
// [RULE_12] Host keeps the enable pin high in normal use.
// [RULE_13] Host drives glitch-free serial clock and data.
// [RULE_14] Write is address with bit 0 low, register byte, data byte.
// [RULE_15] Each received byte is acknowledged low on the ninth clock.
// [RULE_16] Any accepted write re-evaluates gain after the set delay.
module ldg_top
   import ldg_pkg::*;
#(
   parameter int P_DLY0_US = 3000, // Delay range 0
   parameter int P_DLY1_US = 1500, // Delay range 1
   parameter int P_DLY2_US = 6000, // Delay range 2
   parameter int P_DLY3_US = 12000, // Delay range 3
   parameter int CW = 24 // Delay counter width
) (
   input wire logic i_clock, // 10 MHz clock
   input wire logic i_rst, // Async reset, high
   input wire logic i_hw_enable_reset_pin, // Low clears all control state
   input wire logic i_scl, // Serial clock
   input wire logic i_sda, // Serial data in
   output logic o_sda_out, // Serial data out value
   output logic o_sda_oe, // Serial data drive enable
   input wire logic [3:0] i_hr_low_primary, // Primary sinks low
   input wire logic i_hr_low_d53, // Shared sink 5 low
   input wire logic i_hr_low_d62, // Shared sink 6 low
   input wire logic i_hr_low_secondary, // Secondary sink low
   input wire logic i_hr_low_indicator, // Indicator sink low
   output logic o_primary_group_enable, // Primary sinks on
   output logic o_secondary_group_enable, // Secondary sinks on
   output logic o_indicator_enable, // Indicator sink on
   output logic o_d53_off, // Sink 5 shut down
   output logic o_d62_off, // Sink 6 shut down
   output logic o_d53_primary, // Sink 5 in primary group
   output logic o_d62_primary, // Sink 6 in primary group
   output logic [BRT_A_W-1:0] o_primary_level, // Primary code
   output logic [BRT_BC_W-1:0] o_secondary_level, // Secondary code
   output logic [BRT_BC_W-1:0] o_indicator_level, // Indicator code
   output logic [RAMP_W-1:0] o_ramp_step, // Ramp step select
   output logic o_gain_3x2 // Pump gain 3/2
);
   localparam int DLY0_CYC = (P_DLY0_US * CLK_KHZ + 999) / 1000;
   localparam int DLY1_CYC = (P_DLY1_US * CLK_KHZ + 999) / 1000;
   localparam int DLY2_CYC = (P_DLY2_US * CLK_KHZ + 999) / 1000;
   localparam int DLY3_CYC = (P_DLY3_US * CLK_KHZ + 999) / 1000;
   localparam logic [CW-1:0] DLY0 = CW'(DLY0_CYC < 1 ? 1 : DLY0_CYC);
   localparam logic [CW-1:0] DLY1 = CW'(DLY1_CYC < 1 ? 1 : DLY1_CYC);
   localparam logic [CW-1:0] DLY2 = CW'(DLY2_CYC < 1 ? 1 : DLY2_CYC);
   localparam logic [CW-1:0] DLY3 = CW'(DLY3_CYC < 1 ? 1 : DLY3_CYC);

   ldg_wr_if wr ();

   logic clear;
   logic [7:0] gp_ff, nxt_gp;
   logic [BRT_A_W-1:0] brt_a_ff, nxt_brt_a;
   logic [BRT_BC_W-1:0] brt_b_ff, nxt_brt_b;
   logic [BRT_BC_W-1:0] brt_c_ff, nxt_brt_c;
   logic [RAMP_W-1:0] ramp_ff, nxt_ramp;
   logic [VF_W-1:0] vf_ff, nxt_vf;
   logic [SINKS-1:0] hr_low;
   logic [SINKS-1:0] mask;
   logic [CW-1:0] delay;
   logic pri_en, sec_en, ind_en;

   // Enable pin low acts as a synchronous clear of all control state
   assign clear = ~i_hw_enable_reset_pin; // RULE_11

   ldg_serial_slave u_slave (
      .i_clock (i_clock),
      .i_rst (i_rst),
      .i_clear (clear),
      .i_scl (i_scl),
      .i_sda (i_sda),
      .o_sda_oe (o_sda_oe),
      .wr (wr.src)
   );

   // Open drain: only ever pulls low
   assign o_sda_out = 1'b0;

   always_comb begin
      nxt_gp = gp_ff;
      nxt_brt_a = brt_a_ff;
      nxt_brt_b = brt_b_ff;
      nxt_brt_c = brt_c_ff;
      nxt_ramp = ramp_ff;
      nxt_vf = vf_ff;
      if (clear) begin
         nxt_gp = RST_GP; // RULE_11
         nxt_brt_a = RST_BRT_A[BRT_A_W-1:0];
         nxt_brt_b = RST_BRT_B[BRT_BC_W-1:0];
         nxt_brt_c = RST_BRT_C[BRT_BC_W-1:0];
         nxt_ramp = RST_RAMP[RAMP_W-1:0];
         nxt_vf = RST_VF_DLY[VF_W-1:0];
      end else if (wr.valid) begin
         // Unmapped selects are acknowledged and dropped
         unique case (wr.addr)
            REG_GP: nxt_gp = {1'b0, wr.data[6:0]}; // RULE_03
            REG_BRT_A: nxt_brt_a = wr.data[BRT_A_W-1:0]; // RULE_01
            REG_BRT_B: nxt_brt_b = wr.data[BRT_BC_W-1:0]; // RULE_02
            REG_BRT_C: nxt_brt_c = wr.data[BRT_BC_W-1:0]; // RULE_02
            REG_RAMP: nxt_ramp = wr.data[RAMP_W-1:0];
            REG_VF_DLY: nxt_vf = wr.data[VF_W-1:0]; // RULE_10
            default: nxt_gp = gp_ff;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gp_ff <= RST_GP;
         brt_a_ff <= RST_BRT_A[BRT_A_W-1:0];
         brt_b_ff <= RST_BRT_B[BRT_BC_W-1:0];
         brt_c_ff <= RST_BRT_C[BRT_BC_W-1:0];
         ramp_ff <= RST_RAMP[RAMP_W-1:0];
         vf_ff <= RST_VF_DLY[VF_W-1:0];
      end else begin
         gp_ff <= nxt_gp;
         brt_a_ff <= nxt_brt_a;
         brt_b_ff <= nxt_brt_b;
         brt_c_ff <= nxt_brt_c;
         ramp_ff <= nxt_ramp;
         vf_ff <= nxt_vf;
      end
   end

   assign pri_en = gp_ff[GP_PRI_EN];
   assign sec_en = gp_ff[GP_SEC_EN];
   assign ind_en = gp_ff[GP_IND_EN];

   // Sinks 5 and 6 follow the group they are assigned to
   assign hr_low = {i_hr_low_indicator, i_hr_low_secondary,
                    i_hr_low_d62, i_hr_low_d53, i_hr_low_primary};
   assign mask[3:0] = {4{pri_en}}; // RULE_07
   assign mask[4] = ~gp_ff[GP_SD53] & (gp_ff[GP_A53] ? pri_en : sec_en);
   assign mask[5] = ~gp_ff[GP_SD62] & (gp_ff[GP_A62] ? pri_en : sec_en);
   assign mask[6] = sec_en;
   assign mask[7] = ind_en;

   always_comb begin
      unique case (vf_ff) // RULE_10
         2'h0: delay = DLY0; // RULE_09
         2'h1: delay = DLY1;
         2'h2: delay = DLY2;
         2'h3: delay = DLY3;
      endcase
   end

   ldg_gain_ctl #(
      .CW (CW)
   ) u_gain (
      .i_clock (i_clock),
      .i_rst (i_rst),
      .i_clear (clear),
      .i_write (wr.valid), // RULE_16
      .i_hr_low (hr_low),
      .i_mask (mask),
      .i_delay (delay),
      .o_gain_3x2 (o_gain_3x2)
   );

   assign o_primary_group_enable = pri_en;
   assign o_secondary_group_enable = sec_en;
   assign o_indicator_enable = ind_en;
   assign o_d53_off = gp_ff[GP_SD53];
   assign o_d62_off = gp_ff[GP_SD62];
   assign o_d53_primary = gp_ff[GP_A53];
   assign o_d62_primary = gp_ff[GP_A62];
   assign o_primary_level = brt_a_ff;
   assign o_secondary_level = brt_b_ff;
   assign o_indicator_level = brt_c_ff;
   assign o_ramp_step = ramp_ff;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_pin_reset;
      !i_hw_enable_reset_pin |=> gp_ff == RST_GP && !o_gain_3x2
         && brt_a_ff == RST_BRT_A[BRT_A_W-1:0] && !o_sda_oe;
   endproperty
   a_pin_reset: assert property (p_pin_reset) // RULE_11
      else $error("Enable pin low did not restore defaults");

   property p_enable_by_write;
      !$stable(gp_ff) |-> $past(wr.valid) || $past(clear);
   endproperty
   a_enable_by_write: assert property (p_enable_by_write) // RULE_03
      else $error("Enables changed without a serial write");

   sequence s_write_to(logic [7:0] sel);
      wr.valid && !clear && wr.addr == sel;
   endsequence

   property p_primary_code;
      s_write_to(REG_BRT_A) |=>
         o_primary_level == $past(wr.data[BRT_A_W-1:0]);
   endproperty
   a_primary_code: assert property (p_primary_code) // RULE_01
      else $error("Primary code not taken from write");

   property p_indicator_code;
      s_write_to(REG_BRT_C) |=>
         o_indicator_level == $past(wr.data[BRT_BC_W-1:0])
         && $stable(o_secondary_level);
   endproperty
   a_indicator_code: assert property (p_indicator_code) // RULE_02
      else $error("Indicator code not taken from write");

   property p_delay_select;
      s_write_to(REG_VF_DLY) ##1 wr.data[VF_W-1:0] == 2'h0 |->
         delay == DLY0;
   endproperty
   a_delay_select: assert property (p_delay_select) // RULE_10
      else $error("Delay range not applied");

   property p_disabled_ignored;
      !pri_en && !sec_en && !ind_en && !o_gain_3x2 && !wr.valid
         |=> !o_gain_3x2;
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) // RULE_07
      else $error("Disabled sinks moved the gain");

   property p_secondary_code;
      s_write_to(REG_BRT_B) |=>
         o_secondary_level == $past(wr.data[BRT_BC_W-1:0])
         && $stable(o_indicator_level);
   endproperty
   a_secondary_code: assert property (p_secondary_code) // RULE_02
      else $error("Secondary code not taken from write");

   property p_enable_code;
      s_write_to(REG_GP) |=> gp_ff == {1'b0, $past(wr.data[6:0])};
   endproperty
   a_enable_code: assert property (p_enable_code) // RULE_03
      else $error("Enable bits not taken from write");

   property p_ramp_code;
      s_write_to(REG_RAMP) |=>
         o_ramp_step == $past(wr.data[RAMP_W-1:0]);
   endproperty
   a_ramp_code: assert property (p_ramp_code) // RULE_03
      else $error("Ramp step not taken from write");

   property p_delay_field;
      s_write_to(REG_VF_DLY) |=> vf_ff == $past(wr.data[VF_W-1:0]);
   endproperty
   a_delay_field: assert property (p_delay_field) // RULE_10
      else $error("Delay field not taken from write");

   // Nothing but a write or the enable pin may move control state
   property p_regs_hold;
      !wr.valid && !clear |=> $stable(gp_ff) && $stable(brt_a_ff)
         && $stable(brt_b_ff) && $stable(brt_c_ff)
         && $stable(ramp_ff) && $stable(vf_ff);
   endproperty
   a_regs_hold: assert property (p_regs_hold) // RULE_03
      else $error("Control state moved without a write");

   property p_pin_reset_rest;
      !i_hw_enable_reset_pin |=>
         brt_b_ff == RST_BRT_B[BRT_BC_W-1:0]
         && brt_c_ff == RST_BRT_C[BRT_BC_W-1:0]
         && ramp_ff == RST_RAMP[RAMP_W-1:0]
         && vf_ff == RST_VF_DLY[VF_W-1:0];
   endproperty
   a_pin_reset_rest: assert property (p_pin_reset_rest) // RULE_11
      else $error("Enable pin low left a level set");

   // A shut sink is never monitored, whichever group it joins
   property p_shut_d53;
      gp_ff[GP_SD53] |-> !mask[4];
   endproperty
   a_shut_d53: assert property (p_shut_d53) // RULE_07
      else $error("Shut sink 5 still monitored");

   property p_shut_d62;
      gp_ff[GP_SD62] |-> !mask[5];
   endproperty
   a_shut_d62: assert property (p_shut_d62) // RULE_07
      else $error("Shut sink 6 still monitored");

   property p_routed_d53;
      !gp_ff[GP_SD53] && gp_ff[GP_A53] |-> mask[4] == pri_en;
   endproperty
   a_routed_d53: assert property (p_routed_d53) // RULE_07
      else $error("Sink 5 not following the primary group");

   property p_routed_d62;
      !gp_ff[GP_SD62] && !gp_ff[GP_A62] |-> mask[5] == sec_en;
   endproperty
   a_routed_d62: assert property (p_routed_d62) // RULE_07
      else $error("Sink 6 not following the secondary group");
endmodule

// file: verif/ldg_host_model.sv
`timescale 1ns/1ps
module ldg_host_model (
   input wire logic i_clock, // Device clock, paces the bus
   input wire logic i_sda, // Resolved data line
   output logic o_scl, // Serial clock
   output logic o_sda_low // Pull data line low
);
   // Bus idles with clock high and data released to the pull-up
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   // Data moves only while the clock is low, one line at a time
   task automatic send_bit(input logic b);
      o_sda_low = ~b;
      wait_clk(2);
      o_scl = 1'b1;
      wait_clk(3);
      o_scl = 1'b0;
      wait_clk(1);
   endtask

   // Eight bits MSB first, then the line is released for the answer
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      o_sda_low = 1'b0;
      wait_clk(2);
      o_scl = 1'b1;
      wait_clk(1);
      ack = ~i_sda;
      wait_clk(2);
      o_scl = 1'b0;
      wait_clk(1);
   endtask

   // Target with write direction, register select, then one data byte
   task automatic write_frame(input logic [6:0] dev, input logic [7:0] sel,
      input logic [7:0] val, output logic [2:0] acks);
      o_sda_low = 1'b1;
      wait_clk(3);
      o_scl = 1'b0;
      wait_clk(1);
      send_byte({dev, 1'b0}, acks[2]);
      send_byte(sel, acks[1]);
      send_byte(val, acks[0]);
      o_sda_low = 1'b1;
      wait_clk(2);
      o_scl = 1'b1;
      wait_clk(2);
      o_sda_low = 1'b0;
      wait_clk(3);
   endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import ldg_pkg::*;
   localparam int DLY_US [4] = '{1, 2, 3, 4};
   logic i_clock, i_rst, i_hw_enable_reset_pin;
   logic scl, host_low, sda, sda_oe, sda_out;
   logic [3:0] hr_p;
   logic hr_s, hr_i, hr_53, hr_62;
   logic en_p, en_s, en_i, d53_off, d62_off, d53_p, d62_p, gain;
   logic [4:0] lvl_p;
   logic [2:0] lvl_s, lvl_i;
   logic [1:0] ramp;
   logic [7:0] gp_now;
   int num_errors = 0;
   int check_count = 0;

   assign sda = ~(host_low | sda_oe);
   assign gp_now = {1'b0, d62_p, d53_p, d62_off, d53_off, en_i, en_s, en_p};

   ldg_host_model ldg_host_model_inst (.i_clock(i_clock), .i_sda(sda),
      .o_scl(scl), .o_sda_low(host_low));

   ldg_top #(.P_DLY0_US(DLY_US[0]), .P_DLY1_US(DLY_US[1]),
      .P_DLY2_US(DLY_US[2]), .P_DLY3_US(DLY_US[3])) ldg_top_inst (
      .i_clock(i_clock), .i_rst(i_rst),
      .i_hw_enable_reset_pin(i_hw_enable_reset_pin),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_hr_low_primary(hr_p), .i_hr_low_d53(hr_53), .i_hr_low_d62(hr_62),
      .i_hr_low_secondary(hr_s), .i_hr_low_indicator(hr_i),
      .o_primary_group_enable(en_p), .o_secondary_group_enable(en_s),
      .o_indicator_enable(en_i), .o_d53_off(d53_off), .o_d62_off(d62_off),
      .o_d53_primary(d53_p), .o_d62_primary(d62_p),
      .o_primary_level(lvl_p), .o_secondary_level(lvl_s),
      .o_indicator_level(lvl_i), .o_ramp_step(ramp), .o_gain_3x2(gain));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   function automatic int dly_cycles(input int f);
      return DLY_US[f] * CLK_KHZ / 1000;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] sel, input logic [7:0] val);
      logic [2:0] acks;
      ldg_host_model_inst.write_frame(DEV_ADDR, sel, val, acks);
      check({5'h0, acks}, 8'h07, "acknowledge");
      tick(2);
   endtask

   task automatic check_defaults();
      check(gp_now, 8'h00, "enables");
      check({3'h0, lvl_p}, 8'h00, "primary level");
      check({2'h0, lvl_s, lvl_i}, 8'h00, "group levels");
      check({5'h0, ramp, gain}, 8'h00, "ramp and gain");
      check({6'h0, sda_out, sda_oe}, 8'h00, "data line idle");
   endtask

   initial begin
      repeat (60000) @(posedge i_clock);
      num_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      test_done();
   end

   initial begin
      logic [7:0] v;
      logic [2:0] acks;
      int d;
      i_rst = 1'b1;
      i_hw_enable_reset_pin = 1'b1;
      hr_p = 4'h0;
      hr_s = 1'b0;
      hr_i = 1'b0;
      hr_53 = 1'b0;
      hr_62 = 1'b0;
      void'($urandom(32'h9337));
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      tick(3);
      check_defaults();
      // No group enabled: low sinks must not move the gain
      hr_p = 4'hf;
      tick(20);
      check({7'h0, gain}, 8'h00, "all groups off");
      hr_p = 4'h0;
      // Group enables and sink routing from random bytes
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         wr(REG_GP, v);
         check(gp_now, {1'b0, v[6:0]}, "enable bits");
      end
      // Primary codes: both ends of the range plus random ones
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'he0 : (i == 1) ? 8'hff : 8'($urandom);
         wr(REG_BRT_A, v);
         check({3'h0, lvl_p}, {3'h0, v[4:0]}, "primary code");
      end
      for (int c = 0; c < 8; c++) begin
         v = 8'($urandom);
         wr(REG_BRT_B, {v[7:3], 3'(c)});
         wr(REG_BRT_C, {v[7:3], 3'(7 - c)});
         check({2'h0, lvl_s, lvl_i}, 8'(7 * c + 7), "codes");
      end
      v = 8'($urandom);
      wr(REG_RAMP, v);
      check({6'h0, ramp}, {6'h0, v[1:0]}, "ramp step");
      // Unmapped select is answered but changes nothing
      wr(8'h55, 8'h00);
      check({2'h0, lvl_s, lvl_i}, 8'h38, "unmapped write");
      // Wrong target address gets no answer and no effect
      ldg_host_model_inst.write_frame(DEV_ADDR ^ 7'h01, REG_BRT_B, 8'h00,
         acks);
      check({5'h0, acks}, 8'h00, "foreign address");
      check({5'h0, lvl_s}, 8'h07, "foreign address data");
      // Gain hysteresis under each delay range, primary group only
      wr(REG_GP, 8'h01);
      for (int f = 0; f < 4; f++) begin
         wr(REG_VF_DLY, {6'h3f, 2'(f)});
         tick(50);
         d = dly_cycles(f);
         hr_p = 4'h1;
         tick(d - 3);
         hr_p = 4'h0;
         tick(5);
         check({7'h0, gain}, 8'h00, "short dip");
         hr_p = 4'h8;
         tick(d + 4);
         check({7'h0, gain}, 8'h01, "long dip");
         hr_p = 4'h0;
         tick(d + 5);
         check({7'h0, gain}, 8'h01, "gain held");
         wr(8'h55, 8'h00);
         check({7'h0, gain}, {7'h0, 1'(f > 0)}, "delay first");
         tick(d + 5);
         check({7'h0, gain}, 8'h00, "pass mode again");
      end
      // Disabled groups are ignored until a write enables them
      wr(REG_VF_DLY, 8'hfc);
      tick(50);
      hr_s = 1'b1;
      hr_i = 1'b1;
      hr_53 = 1'b1;
      hr_62 = 1'b1;
      tick(50);
      check({7'h0, gain}, 8'h00, "disabled sinks");
      // Sink 5 moved to primary but shut down, sink 6 left on secondary
      wr(REG_GP, 8'h29);
      tick(30);
      check({7'h0, gain}, 8'h00, "shut and routed sinks");
      hr_s = 1'b0;
      hr_53 = 1'b0;
      hr_62 = 1'b0;
      wr(REG_GP, 8'h07);
      tick(30);
      check({7'h0, gain}, 8'h01, "indicator lowest");
      hr_i = 1'b0;
      // Enable pin low clears all control state
      i_hw_enable_reset_pin = 1'b0;
      tick(2);
      i_hw_enable_reset_pin = 1'b1;
      tick(2);
      check_defaults();
      wr(REG_BRT_A, 8'h05);
      check({3'h0, lvl_p}, 8'h05, "write after clear");
      test_done();
   end
endmodule
